// ===== hsd_pkg.sv
// package: register map, reset values and carriers of the hall datapath
package hsd_pkg;
    // apb register byte addresses
    localparam logic [7:0] HSD_ADDR_CTRL = 8'h00;
    localparam logic [7:0] HSD_ADDR_GAIN = 8'h04;
    localparam logic [7:0] HSD_ADDR_OFFSET = 8'h08;
    localparam logic [7:0] HSD_ADDR_TEMPCO = 8'h0C;
    localparam logic [7:0] HSD_ADDR_REFTEMP = 8'h10;
    localparam logic [7:0] HSD_ADDR_STATUS = 8'h14;
    // field positions
    localparam int HSD_CTRL_RANGE_LSB = 0;
    localparam int HSD_CTRL_FILT_LSB = 4;
    localparam int HSD_TEMPCO_LIN_LSB = 0;
    localparam int HSD_TEMPCO_QUAD_LSB = 16;
    localparam int HSD_STATUS_CODE_LSB = 0;
    localparam int HSD_STATUS_LEVEL_LSB = 16;
    // range codes
    localparam logic [1:0] HSD_RANGE_50MT = 2'h3;
    localparam logic [1:0] HSD_RANGE_100MT = 2'h1;
    localparam logic [1:0] HSD_RANGE_200MT = 2'h0;
    localparam logic [1:0] HSD_RANGE_BAD = 2'h2;
    // reset values
    localparam logic [1:0] HSD_RANGE_RST = HSD_RANGE_100MT;
    localparam logic [2:0] HSD_FILT_RST = 3'h7;
    localparam logic [14:0] HSD_GAIN_RST = 15'h4000;
    localparam logic [14:0] HSD_OFFSET_RST = 15'h4000;
    localparam logic [8:0] HSD_LIN_RST = 9'h000;
    localparam logic [7:0] HSD_QUAD_RST = 8'h00;
    localparam logic [2:0] HSD_REF_RST = 3'h0;
    // arithmetic constants
    localparam logic [2:0] HSD_FILT_OFF = 3'h7;
    localparam logic [15:0] HSD_WORD_BIAS = 16'h4000;
    localparam logic [23:0] HSD_COMP_ONE = 24'h010000;
    localparam int HSD_FILT_FRAC = 8;
    localparam int HSD_REF_SHIFT = 8;
    localparam int HSD_QUAD_SHIFT = 8;
    localparam int HSD_GAIN_SHIFT = 16;
    localparam int HSD_MUL_SHIFT = 16;
    localparam logic [11:0] HSD_CODE_MAX = 12'hFFF;
    localparam logic [11:0] HSD_CODE_MIN = 12'h000;
    localparam int HSD_FIFO_DEPTH = 32;
    // converter sample carrier
    typedef struct packed {
        logic [15:0] field;
        logic [11:0] temp;
    } hsd_sample_t;
endpackage

// ===== hsd_fifo.sv
// fifo: parameterised width and depth, valid/ready both sides
`timescale 1ns/1ps
module hsd_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_r];
    assign level = count_r;

    // storage
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            if (push && !pop)
            begin
                count_r <= count_r + (AW+1)'(1);
            end
            else if (pop && !push)
            begin
                count_r <= count_r - (AW+1)'(1);
            end
        end
    end
endmodule

// ===== hsd_datapath.sv
// hall datapath: filter, compensated gain, offset, 12-bit limiter, apb regs
//
// Functional notes
// - range code 3/1/0 selects 50/100/200 mT
// - low pass filter before any scaling
// - multiply sample by gain times compensation
// - add programmed offset after gain multiply
// - limit result to 12 bits for dac
// - temperature minus reference temperature
// - linear and squared temperature coefficient terms
// - temperature terms sum times gain word
// - gain equals (word minus 16384) over 4096
// - offset equals word minus 16384, in dac codes
// - eight filter steps, 7 off, unity dc
`timescale 1ns/1ps
module hsd_datapath
    import hsd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter samples
    input wire logic adc_valid,
    output logic adc_ready,
    input wire hsd_sample_t adc_sample,
    output logic [1:0] converter_range,
    // dac side
    output logic dac_valid,
    input wire logic dac_ready,
    output logic [11:0] dac_code
);
    logic [1:0] range_select_r;
    logic [2:0] filter_setting_r;
    logic [14:0] gain_word_r;
    logic [14:0] offset_word_r;
    logic [8:0] linear_temp_coeff_r;
    logic [7:0] quadratic_temp_coeff_r;
    logic [2:0] reference_temperature_r;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rdata_nxt;
    logic [5:0] fifo_level;
    logic fifo_valid;
    hsd_sample_t fifo_data;
    logic adv;
    logic pop;
    logic signed [23:0] filt_acc_r;
    logic signed [23:0] filt_acc_nxt;
    logic signed [12:0] tnorm_r;
    logic signed [12:0] tnorm_nxt;
    logic v1_r;
    logic signed [15:0] field2_r;
    logic signed [23:0] eff_gain_r;
    logic signed [23:0] eff_gain_nxt;
    logic v2_r;
    logic [11:0] dac_code_r;
    logic [11:0] dac_code_nxt;
    logic signed [25:0] sum_nxt;
    logic dac_valid_r;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !pwrite;
    assign pready = 1'b1;
    assign converter_range = range_select_r;
    assign dac_valid = dac_valid_r;
    assign dac_code = dac_code_r;

    // address decode
    always_comb
    begin
        addr_ok = 1'b1;
        rdata_nxt = 32'h00000000;
        case (paddr)
            HSD_ADDR_CTRL:
            begin
                rdata_nxt[HSD_CTRL_RANGE_LSB +: 2] = range_select_r;
                rdata_nxt[HSD_CTRL_FILT_LSB +: 3] = filter_setting_r;
            end
            HSD_ADDR_GAIN: rdata_nxt[14:0] = gain_word_r;
            HSD_ADDR_OFFSET: rdata_nxt[14:0] = offset_word_r;
            HSD_ADDR_TEMPCO:
            begin
                rdata_nxt[HSD_TEMPCO_LIN_LSB +: 9] = linear_temp_coeff_r;
                rdata_nxt[HSD_TEMPCO_QUAD_LSB +: 8] = quadratic_temp_coeff_r;
            end
            HSD_ADDR_REFTEMP: rdata_nxt[2:0] = reference_temperature_r;
            HSD_ADDR_STATUS:
            begin
                rdata_nxt[HSD_STATUS_CODE_LSB +: 12] = dac_code_r;
                rdata_nxt[HSD_STATUS_LEVEL_LSB +: 6] = fifo_level;
            end
            default: addr_ok = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addr_ok;
    assign prdata = (psel && penable && rd_en) ? rdata_nxt : 32'h00000000;

    // register writes
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            range_select_r <= HSD_RANGE_RST;
            filter_setting_r <= HSD_FILT_RST;
            gain_word_r <= HSD_GAIN_RST;
            offset_word_r <= HSD_OFFSET_RST;
            linear_temp_coeff_r <= HSD_LIN_RST;
            quadratic_temp_coeff_r <= HSD_QUAD_RST;
            reference_temperature_r <= HSD_REF_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                HSD_ADDR_CTRL:
                begin
                    if (pwdata[HSD_CTRL_RANGE_LSB +: 2] != HSD_RANGE_BAD)
                    begin
                        range_select_r <= pwdata[HSD_CTRL_RANGE_LSB +: 2];
                    end
                    filter_setting_r <= pwdata[HSD_CTRL_FILT_LSB +: 3];
                end
                HSD_ADDR_GAIN: gain_word_r <= pwdata[14:0];
                HSD_ADDR_OFFSET: offset_word_r <= pwdata[14:0];
                HSD_ADDR_TEMPCO:
                begin
                    linear_temp_coeff_r <= pwdata[HSD_TEMPCO_LIN_LSB +: 9];
                    quadratic_temp_coeff_r <= pwdata[HSD_TEMPCO_QUAD_LSB +: 8];
                end
                HSD_ADDR_REFTEMP: reference_temperature_r <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // sample buffer
    hsd_fifo #(
        .WIDTH($bits(hsd_sample_t)),
        .DEPTH(HSD_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(adc_valid),
        .in_ready(adc_ready),
        .in_data(adc_sample),
        .out_valid(fifo_valid),
        .out_ready(adv),
        .out_data(fifo_data),
        .level(fifo_level)
    );

    // pipeline advances unless dac stalls
    assign adv = !dac_valid_r || dac_ready;
    assign pop = fifo_valid && adv;

    // filter and normalised temperature
    always_comb
    begin
        logic signed [23:0] x;
        logic signed [24:0] diff;
        x = {fifo_data.field, 8'h00};
        // one extra bit so a full-scale swing cannot wrap
        diff = 25'(x) - 25'(filt_acc_r);
        if (filter_setting_r == HSD_FILT_OFF)
        begin
            filt_acc_nxt = x;
        end
        else
        begin
            filt_acc_nxt = filt_acc_r + 24'(diff >>> (3'h7 - filter_setting_r));
        end
        tnorm_nxt = $signed({1'b0, fifo_data.temp})
            - $signed({2'b00, reference_temperature_r, 8'h00});
    end

    // stage one
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            filt_acc_r <= 24'sh000000;
            tnorm_r <= 13'sh0000;
            v1_r <= 1'b0;
        end
        else if (adv)
        begin
            v1_r <= fifo_valid;
            if (pop)
            begin
                filt_acc_r <= filt_acc_nxt;
                tnorm_r <= tnorm_nxt;
            end
        end
    end

    // compensation factor times gain
    always_comb
    begin
        logic signed [39:0] lin;
        logic signed [39:0] quad;
        logic signed [39:0] comp;
        logic signed [15:0] gain;
        logic signed [39:0] prod;
        lin = 40'($signed(linear_temp_coeff_r)) * 40'(tnorm_r);
        quad = (40'($signed(quadratic_temp_coeff_r)) * 40'(tnorm_r) * 40'(tnorm_r)) >>> HSD_QUAD_SHIFT;
        comp = 40'($signed(HSD_COMP_ONE)) + lin + quad;
        gain = $signed({1'b0, gain_word_r}) - $signed(HSD_WORD_BIAS);
        prod = 40'(gain) * 40'($signed(comp[23:0]));
        eff_gain_nxt = prod[HSD_GAIN_SHIFT +: 24];
    end

    // stage two
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            field2_r <= 16'sh0000;
            eff_gain_r <= 24'sh000000;
            v2_r <= 1'b0;
        end
        else if (adv)
        begin
            v2_r <= v1_r;
            field2_r <= filt_acc_r[HSD_FILT_FRAC +: 16];
            eff_gain_r <= eff_gain_nxt;
        end
    end

    // scale, offset, limit
    always_comb
    begin
        logic signed [39:0] scaled;
        logic signed [15:0] ofs;
        scaled = 40'(field2_r) * 40'(eff_gain_r);
        ofs = $signed({1'b0, offset_word_r}) - $signed(HSD_WORD_BIAS);
        sum_nxt = 26'($signed(scaled[39:HSD_MUL_SHIFT])) + 26'(ofs);
        if (sum_nxt > $signed({14'h0000, HSD_CODE_MAX}))
        begin
            dac_code_nxt = HSD_CODE_MAX;
        end
        else if (sum_nxt < 26'sh0000000)
        begin
            dac_code_nxt = HSD_CODE_MIN;
        end
        else
        begin
            dac_code_nxt = sum_nxt[11:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            dac_code_r <= HSD_CODE_MIN;
            dac_valid_r <= 1'b0;
        end
        else if (adv)
        begin
            dac_valid_r <= v2_r;
            if (v2_r)
            begin
                dac_code_r <= dac_code_nxt;
            end
        end
    end

    property p_range_legal;
        @(posedge clk) disable iff (!rst_b)
        range_select_r != HSD_RANGE_BAD;
    endproperty
    a_range_legal: assert property (p_range_legal) else $error("illegal range code held");

    property p_range_out;
        @(posedge clk) disable iff (!rst_b)
        wr_en && paddr == HSD_ADDR_CTRL && pwdata[1:0] == HSD_RANGE_50MT |=> converter_range == HSD_RANGE_50MT;
    endproperty
    a_range_out: assert property (p_range_out) else $error("range code not applied");

    property p_filter_off;
        @(posedge clk) disable iff (!rst_b)
        pop && filter_setting_r == HSD_FILT_OFF |=> filt_acc_r[23:8] == $past(fifo_data.field);
    endproperty
    a_filter_off: assert property (p_filter_off) else $error("bypassed filter altered sample");

    property p_filter_dc;
        @(posedge clk) disable iff (!rst_b)
        pop && filt_acc_r == $signed({fifo_data.field, 8'h00}) |=> $stable(filt_acc_r);
    endproperty
    a_filter_dc: assert property (p_filter_dc) else $error("filter dc gain not unity");

    property p_temp_norm;
        @(posedge clk) disable iff (!rst_b)
        pop |=> tnorm_r == $signed({1'b0, $past(fifo_data.temp)})
            - $signed({2'b00, $past(reference_temperature_r), 8'h00});
    endproperty
    a_temp_norm: assert property (p_temp_norm) else $error("temperature not normalised");

    property p_unity_gain;
        @(posedge clk) disable iff (!rst_b)
        adv && tnorm_r == 13'sh0000 && gain_word_r == 15'h5000 |=> eff_gain_r == 24'sh001000;
    endproperty
    a_unity_gain: assert property (p_unity_gain) else $error("gain word 20480 not unity");

    property p_zero_gain_offset;
        @(posedge clk) disable iff (!rst_b)
        adv && v2_r && field2_r == 16'sh0000 && offset_word_r == 15'h4800 |=> dac_code == 12'h800;
    endproperty
    a_zero_gain_offset: assert property (p_zero_gain_offset) else $error("offset not added");

    property p_saturate_high;
        @(posedge clk) disable iff (!rst_b)
        adv && v2_r && sum_nxt > 26'sh0000FFF |=> dac_valid && dac_code == HSD_CODE_MAX;
    endproperty
    a_saturate_high: assert property (p_saturate_high) else $error("overflow wrapped");

    property p_saturate_low;
        @(posedge clk) disable iff (!rst_b)
        adv && v2_r && sum_nxt < 26'sh0000000 |=> dac_valid && dac_code == HSD_CODE_MIN;
    endproperty
    a_saturate_low: assert property (p_saturate_low) else $error("underflow wrapped");

    property p_dac_hold;
        @(posedge clk) disable iff (!rst_b)
        dac_valid && !dac_ready |=> dac_valid && $stable(dac_code);
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("dac code dropped under stall");

    property p_latency;
        @(posedge clk) disable iff (!rst_b)
        pop && dac_ready && !dac_valid ##1 dac_ready ##1 dac_ready |=> dac_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("sample took more than three cycles");
endmodule

// ===== hsd_conv_model.sv
// converter and dac model facing the hall datapath
`timescale 1ns/1ps
module hsd_conv_model
    import hsd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // converter side
    output logic adc_valid,
    input wire logic adc_ready,
    output hsd_sample_t adc_sample,
    // dac side
    input wire logic dac_valid,
    output logic dac_ready,
    input wire logic [11:0] dac_code,
    // 0 ready, 1 random stall, 2 hold off
    input wire logic [1:0] stall
);
    hsd_sample_t pend[$];
    logic [11:0] got[$];
    logic [7:0] lfsr = 8'h5A;
    task automatic push(input hsd_sample_t s);
        pend.push_back(s);
    endtask
    initial
    begin
        adc_valid = 1'b0;
        adc_sample = '0;
        dac_ready = 1'b0;
    end
    // sample held until taken, bus scrambled when idle
    always @(posedge clk)
    begin
        if (adc_valid && adc_ready)
            void'(pend.pop_front());
        if (dac_valid && dac_ready)
            got.push_back(dac_code);
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        dac_ready <= rst_b && (stall == 2'h0 || (stall == 2'h1 && lfsr[0]));
        adc_valid <= rst_b && pend.size() > 0;
        adc_sample <= (rst_b && pend.size() > 0) ? pend[0] : ~adc_sample;
    end
endmodule

// ===== test_hall_signal_datapath.sv
// testbench: hall datapath against an integer reference model
`timescale 1ns/1ps
module test_hall_signal_datapath
    import hsd_pkg::*;
;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err_v;
    logic adc_valid, adc_ready, dac_valid, dac_ready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, seed;
    logic [1:0] converter_range, stall;
    logic [11:0] dac_code;
    hsd_sample_t adc_sample;
    int mismatches, samples_checked, g_v, os_v, lin_v, quad_v, ref_v, flt_v, k, i, last;
    longint acc;
    int exp_q[$];
    logic [1:0] codes[3] = '{HSD_RANGE_50MT, HSD_RANGE_100MT, HSD_RANGE_200MT};

    hsd_datapath dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_sample(adc_sample),
        .converter_range(converter_range), .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_code(dac_code));
    hsd_conv_model conv_u (.clk(clk), .rst_b(rst_b), .adc_valid(adc_valid), .adc_ready(adc_ready),
        .adc_sample(adc_sample), .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_code(dac_code), .stall(stall));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic summarize();
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 50)
        begin
            mismatches++;
            summarize();
        end
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", rd_v, e);
    endtask

    task automatic cfg(input int g, input int os);
        apb(1'b1, HSD_ADDR_GAIN, 32'(g));
        apb(1'b1, HSD_ADDR_OFFSET, 32'(os));
        g_v = g;
        os_v = os;
    endtask

    // reference: filter, compensated gain, offset, saturate
    function automatic int model(int x, int t);
        longint tn, eff, o;
        if (flt_v == 7)
            acc = x * 256;
        else
            acc = acc + ((x * 256 - acc) >>> (7 - flt_v));
        tn = t - ref_v * 256;
        eff = ((g_v - 16384) * (65536 + lin_v * tn + ((quad_v * tn * tn) >>> 8))) >>> 16;
        o = (((acc >>> 8) * eff) >>> 16) + os_v - 16384;
        return o > 4095 ? 4095 : (o < 0 ? 0 : int'(o));
    endfunction

    task automatic send(input int x, input int t);
        hsd_sample_t s;
        s.field = x[15:0];
        s.temp = t[11:0];
        exp_q.push_back(model(x, t));
        conv_u.push(s);
    endtask

    task automatic drain();
        int n;
        for (n = 0; n < 3000 && conv_u.got.size() < exp_q.size(); n++)
            @(posedge clk);
        if (n == 3000)
        begin
            mismatches++;
            summarize();
        end
        while (exp_q.size() > 0)
            chk("dac_code", 32'(conv_u.got.pop_front()), 32'(exp_q.pop_front()));
    endtask

    initial
    begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, stall} = '0;
        {mismatches, samples_checked, lin_v, quad_v, ref_v, acc} = '0;
        seed = 32'd91;
        flt_v = 7;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(HSD_ADDR_CTRL, 32'h71);
        rd(HSD_ADDR_GAIN, 32'h4000);
        rd(HSD_ADDR_OFFSET, 32'h4000);
        rd(HSD_ADDR_TEMPCO, 32'h0);
        rd(HSD_ADDR_REFTEMP, 32'h0);
        foreach (codes[j])
        begin
            apb(1'b1, HSD_ADDR_CTRL, {25'h0, 3'h7, 2'h0, codes[j]});
            rd(HSD_ADDR_CTRL, {25'h0, 3'h7, 2'h0, codes[j]});
            chk("converter_range", 32'(converter_range), 32'(codes[j]));
        end
        apb(1'b1, HSD_ADDR_CTRL, 32'h52);
        rd(HSD_ADDR_CTRL, 32'h50);
        apb(1'b1, HSD_ADDR_STATUS, 32'hFFFFFFFF);
        rd(HSD_ADDR_STATUS, 32'h0);
        apb(1'b1, 8'h18, 32'h1);
        chk("pslverr", 32'(err_v), 32'h1);
        rd(8'h18, 32'h0);
        chk("pslverr", 32'(err_v), 32'h1);
        apb(1'b1, HSD_ADDR_CTRL, 32'h71);
        stall <= 2'h1;
        cfg(32767, 16384);
        send(32767, 0);
        send(-32768, 0);
        drain();
        cfg(20480, 16384);
        send(16384, 0);
        drain();
        for (k = 0; k < 6; k++)
        begin
            seed = rnd();
            cfg(seed[0] ? 18432 + seed[13:1] : int'(seed[13:1]), int'(rnd() & 32'h7FFF));
            repeat (8) send(int'($signed(16'(rnd()))), int'(rnd() & 32'hFFF));
            drain();
        end
        apb(1'b1, HSD_ADDR_TEMPCO, 32'h00040010);
        apb(1'b1, HSD_ADDR_REFTEMP, 32'h1);
        {lin_v, quad_v, ref_v} = {32'd16, 32'd4, 32'd1};
        cfg(20480, 18432);
        send(16384, 512);
        send(16384, 0);
        send(-9000, 4095);
        send(12000, 1000);
        send(0, 2000);
        drain();
        for (k = 7; k >= 0; k--)
        begin
            apb(1'b1, HSD_ADDR_CTRL, 32'((k << 4) | 1));
            flt_v = k;
            send(5000, 256);
            send(5000, 256);
            send(-5000, 256);
            drain();
        end
        stall <= 2'h2;
        for (k = 0; k < 40; k++)
            send(k * 300, 300);
        last = exp_q[$];
        for (i = 0; i < 300 && adc_ready !== 1'b0; i++)
            @(posedge clk);
        apb(1'b0, HSD_ADDR_STATUS, 32'h0);
        chk("fifo level", (rd_v >> 16) & 32'h3F, 32'd32);
        chk("adc_ready", 32'(adc_ready), 32'h0);
        stall <= 2'h1;
        drain();
        rd(HSD_ADDR_STATUS, 32'(last));
        summarize();
    end
endmodule
